//--- src/ecr_ctrl.sv
/*
 * EEPROM control and readback: register pointer, commit transfers, guarded erase and
 * program cycles, CRC check and generation, and the streaming read-data port with its FIFO.
 * Assumes a byte-level I2C engine on the same clock that frames transactions with
 * start and stop pulses and drains read bytes through a valid/ready handshake.
 */
// Notes on behaviour
// - Register-commit bit copies register image into SRAM array, then clears itself.
// - CRC mismatch found while loading EEPROM sets the CRC error flag.
// - With auto CRC on, which is the reset value, programming stores computed CRC.
// - EEPROM loads into registers after reset and on load bit; bit self-clears.
// - Register reads are held off while the EEPROM-to-register load runs.
// - Busy reads one for whole erase or program; EEPROM refuses access then.
// - Erase and program set together run erase followed by program.
// - Erase lasts about 115 ms, covered entirely by busy.
// - Program lasts about 115 ms, covered entirely by busy.
// - Memory start address holds seven bits, resets to zero.
// - Internal address auto-increments; the start address register keeps its written value.
// - Array byte address uses only the low five address bits.
// - Each further read in the transaction returns the next EEPROM byte.
// - After first read-data access the register pointer stops incrementing.
// - Streaming ends with the transaction; normal addressing resumes next time.
// - Cycle counter increments after each erase/program cycle, saturating at 255.
`timescale 1ns/1ns

// ****************************************
// Read-data FIFO
// ****************************************
module ecr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  logic               clk,
  input  logic               rstn,
  // Filling side
  input  logic               in_valid,
  input  logic [W-1:0]       in_data,
  output logic               in_ready,
  // Draining side
  output logic               out_valid,
  output logic [W-1:0]       out_data,
  input  logic               out_ready,
  // Fill level
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  assign level     = cnt_q;
  assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop) rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= in_data;
  end
endmodule : ecr_fifo

// ****************************************
// Control core
// ****************************************
module ecr_ctrl
  import ecr_pkg::*;
#(
  parameter int OP_CYCLES = OP_CYC
) (
  // Clock and reset
  input  logic        clk,
  input  logic        rstn,
  // Transaction framing
  input  logic        txn_start,
  input  logic        txn_stop,
  // Byte writes
  input  logic        wr_valid,
  input  ecr_wr_t     wr,
  // Read requests
  input  logic        rd_req,
  output logic        rd_req_ready,
  // Read answers
  output logic        rd_valid,
  output logic [7:0]  rd_data,
  input  logic        rd_ready
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  ecr_state_t  st_q;
  logic [31:0] tmr_q;
  logic [4:0]  idx_q;
  logic [7:0]  crc_q;
  logic        both_q;
  logic [7:0]  ptr_q;
  logic        strm_q;
  logic [4:0]  ea_q;
  logic [7:0]  memory_start_address_q;
  logic [7:0]  unlk_q;
  logic        cur_ok_q;
  logic        prev_ok_q;
  logic        autocrc_q;
  logic        crcerr_q;
  logic [7:0]  scrc_q;
  logic [7:0]  cnt_q;
  logic        rqr_q;
  logic [7:0]  eeprom  [ARR_WORDS] = '{CNT_IDX: BYTE_ZERO, default: ERASE_VAL};
  logic [7:0]  sram    [ARR_WORDS];
  logic [7:0]  reg_img [ARR_WORDS];
  logic        wr_data;
  logic        ctl_wr;
  logic        rd_take;
  logic        busy;
  logic        tmr_end;
  logic        go_ep;
  logic [7:0]  cnt_nx;
  logic [7:0]  ctl_rd;
  logic [7:0]  rd_byte;
  logic [LW-1:0] f_lvl;

  assign wr_data = wr_valid && !wr.first;
  assign ctl_wr  = wr_data && (ptr_q == ADR_CTL);
  assign rd_take = rd_req && rqr_q;
  assign busy    = (st_q == ST_ERASE) || (st_q == ST_PROG);
  assign tmr_end = (tmr_q == 32'(OP_CYCLES - 1));
  assign cnt_nx  = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 8'h01;
  // Start only from idle and only when the previous transaction unlocked.
  assign go_ep   = ctl_wr && (wr.data[BIT_ERASE] || wr.data[BIT_PROG])
                   && prev_ok_q && (st_q == ST_IDLE);

  // ****************************************
  // Register pointer and streaming
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptr_q <= BYTE_ZERO;
    end else if (wr_valid && wr.first) begin
      ptr_q <= wr.data;
    end else if ((wr_data || rd_take) && ptr_q != ADR_DAT) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      strm_q <= 1'b0;
      ea_q   <= 5'h00;
    end else if (txn_start || txn_stop) begin
      strm_q <= 1'b0;
    end else if (rd_take && ptr_q == ADR_DAT && !busy) begin
      strm_q <= 1'b1;
      ea_q   <= (strm_q ? ea_q : memory_start_address_q[4:0]) + 5'h01;
    end
  end

  // ****************************************
  // Unlock tracking
  // ****************************************
  // Any access other than the unlock write spoils the current transaction.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cur_ok_q  <= 1'b0;
      prev_ok_q <= 1'b0;
    end else if (txn_stop) begin
      prev_ok_q <= cur_ok_q;
      cur_ok_q  <= 1'b0;
    end else if (txn_start) begin
      cur_ok_q <= 1'b0;
    end else if (wr_data) begin
      cur_ok_q <= (ptr_q == ADR_UNLK) && (wr.data == UNLOCK_CODE);
    end else if (rd_take) begin
      cur_ok_q <= 1'b0;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      memory_start_address_q  <= MEMORY_START_ADDRESS_RST;
      unlk_q    <= UNLK_RST;
      autocrc_q <= AUTOCRC_RST;
    end else if (wr_data) begin
      if (ptr_q == ADR_MEM) memory_start_address_q <= {1'b0, wr.data[6:0]};
      if (ptr_q == ADR_UNLK) unlk_q <= wr.data;
      if (ctl_wr) autocrc_q <= wr.data[BIT_AUTOCRC];
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Reset enters the load directly so the image is fetched without software help.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q   <= ST_LOAD;
      idx_q  <= 5'h00;
      crc_q  <= CRC_INIT;
      tmr_q  <= 32'h0;
      both_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          idx_q <= 5'h00;
          crc_q <= CRC_INIT;
          tmr_q <= 32'h0;
          if (go_ep) begin
            st_q   <= wr.data[BIT_ERASE] ? ST_ERASE : ST_PROG;
            both_q <= wr.data[BIT_ERASE] && wr.data[BIT_PROG];
          end else if (ctl_wr && wr.data[BIT_SAVE]) begin
            st_q <= ST_SAVE;
          end else if (ctl_wr && wr.data[BIT_LOAD]) begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          idx_q <= idx_q + 5'h01;
          if (idx_q != CRC_IDX) crc_q <= ecr_crc8(crc_q, eeprom[idx_q]);
          if (idx_q == CRC_IDX) st_q <= ST_IDLE;
        end
        ST_SAVE: begin
          idx_q <= idx_q + 5'h01;
          if (idx_q == CRC_IDX) st_q <= ST_IDLE;
        end
        ST_ERASE: begin
          tmr_q <= tmr_q + 32'h1;
          if (tmr_end) begin
            tmr_q <= 32'h0;
            st_q  <= both_q ? ST_PROG : ST_IDLE;
          end
        end
        ST_PROG: begin
          tmr_q <= tmr_q + 32'h1;
          // CRC is built over the outgoing image while the cell timer runs.
          if (idx_q != CRC_IDX) begin
            idx_q <= idx_q + 5'h01;
            crc_q <= ecr_crc8(crc_q, (idx_q == CNT_IDX) ? cnt_nx : sram[idx_q]);
          end
          if (tmr_end) begin
            tmr_q  <= 32'h0;
            both_q <= 1'b0;
            st_q   <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Status and counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      crcerr_q <= 1'b0;
      scrc_q   <= BYTE_ZERO;
      cnt_q    <= BYTE_ZERO;
    end else if (st_q == ST_LOAD && idx_q == CRC_IDX) begin
      crcerr_q <= (crc_q != eeprom[CRC_IDX]);
      scrc_q   <= eeprom[CRC_IDX];
      cnt_q    <= eeprom[CNT_IDX];
    end else if (busy && tmr_end && !(st_q == ST_ERASE && both_q)) begin
      cnt_q <= cnt_nx;
      if (st_q == ST_PROG && autocrc_q) scrc_q <= crc_q;
    end
  end

  // ****************************************
  // Arrays
  // ****************************************
  // The nonvolatile array has no reset, as cells keep their charge, and starts erased with a zero count.
  always_ff @(posedge clk) begin
    if (st_q == ST_ERASE && tmr_end) begin
      for (int i = 0; i < ARR_WORDS; i++) eeprom[i] <= ERASE_VAL;
      if (!both_q) eeprom[CNT_IDX] <= cnt_nx;
    end else if (st_q == ST_PROG && tmr_end) begin
      for (int i = 0; i < ARR_WORDS; i++) eeprom[i] <= sram[i];
      eeprom[CNT_IDX] <= cnt_nx;
      if (autocrc_q) eeprom[CRC_IDX] <= crc_q;
    end
  end

  always_ff @(posedge clk) begin
    if (st_q == ST_SAVE) sram[idx_q] <= reg_img[idx_q];
  end

  always_ff @(posedge clk) begin
    if (st_q == ST_LOAD) begin
      reg_img[idx_q] <= eeprom[idx_q];
    end else if (wr_data && ptr_q <= ADR_IMG_TOP) begin
      reg_img[ptr_q[4:0]] <= wr.data;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    ctl_rd              = BYTE_ZERO;
    ctl_rd[BIT_SAVE]    = (st_q == ST_SAVE);
    ctl_rd[BIT_CRCERR]  = crcerr_q;
    ctl_rd[BIT_AUTOCRC] = autocrc_q;
    ctl_rd[BIT_LOAD]    = (st_q == ST_LOAD);
    ctl_rd[BIT_BUSY]    = busy;
    ctl_rd[BIT_ERASE]   = (st_q == ST_ERASE);
    ctl_rd[BIT_PROG]    = (st_q == ST_PROG) || (st_q == ST_ERASE && both_q);
  end

  always_comb begin
    rd_byte = BYTE_ZERO;
    if (ptr_q <= ADR_IMG_TOP) begin
      rd_byte = reg_img[ptr_q[4:0]];
    end else begin
      case (ptr_q)
        ADR_SCRC: rd_byte = scrc_q;
        ADR_CNT:  rd_byte = cnt_q;
        ADR_CTL:  rd_byte = ctl_rd;
        ADR_MEM:  rd_byte = memory_start_address_q;
        ADR_UNLK: rd_byte = unlk_q;
        ADR_DAT:  rd_byte = busy ? BYTE_ZERO
                            : eeprom[strm_q ? ea_q : memory_start_address_q[4:0]];
        default:  rd_byte = BYTE_ZERO;
      endcase
    end
  end

  // Ready is registered, so it looks one entry ahead to keep the FIFO from overrunning.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rqr_q <= 1'b0;
    end else begin
      rqr_q <= (st_q != ST_LOAD) && !(st_q == ST_IDLE && ctl_wr && wr.data[BIT_LOAD])
               && (f_lvl < LW'(FIFO_DEPTH - 1));
    end
  end

  assign rd_req_ready = rqr_q;

  ecr_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (rd_take),
    .in_data   (rd_byte),
    .in_ready  (),
    .out_valid (rd_valid),
    .out_data  (rd_data),
    .out_ready (rd_ready),
    .level     (f_lvl)
  );

endmodule : ecr_ctrl

//--- src/ecr_pkg.sv
/*
 * Shared constants, types and helpers for the EEPROM control and readback block.
 * Assumes a 125 MHz internal clock and a byte-wide register engine on the same clock.
 */
package ecr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADR_IMG_TOP = 8'h1f;
  localparam logic [7:0] ADR_SCRC    = 8'h2f;
  localparam logic [7:0] ADR_CNT     = 8'h30;
  localparam logic [7:0] ADR_CTL     = 8'h31;
  localparam logic [7:0] ADR_MEM     = 8'h33;
  localparam logic [7:0] ADR_DAT     = 8'h34;
  localparam logic [7:0] ADR_UNLK    = 8'h38;

  // ****************************************
  // Control and status field positions
  // ****************************************
  localparam int BIT_SAVE    = 6;
  localparam int BIT_CRCERR  = 5;
  localparam int BIT_AUTOCRC = 4;
  localparam int BIT_LOAD    = 3;
  localparam int BIT_BUSY    = 2;
  localparam int BIT_ERASE   = 1;
  localparam int BIT_PROG    = 0;

  // ****************************************
  // Values after reset and codes
  // ****************************************
  localparam logic       AUTOCRC_RST = 1'b1;
  localparam logic [7:0] MEMORY_START_ADDRESS_RST  = 8'h00;
  localparam logic [7:0] UNLK_RST    = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [7:0] UNLOCK_CODE = 8'hbe;
  localparam logic [7:0] ERASE_VAL   = 8'hff;
  localparam logic [7:0] CNT_MAX     = 8'hff;
  localparam logic [7:0] CRC_POLY    = 8'h07;
  localparam logic [7:0] CRC_INIT    = 8'h00;

  // ****************************************
  // Array layout and timing
  // ****************************************
  localparam int         ARR_WORDS = 32;
  localparam logic [4:0] CRC_IDX   = 5'h1f;
  localparam logic [4:0] CNT_IDX   = 5'h1e;
  localparam int         T_OP_MS   = 115;
  localparam longint     CLK_HZ    = 125_000_000;
  localparam longint     OP_CYC_L  = (longint'(T_OP_MS) * CLK_HZ) / 1000;
  localparam int         OP_CYC    = int'(OP_CYC_L);
  localparam int         FIFO_DEPTH = 16;
  localparam int         DATA_W     = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SAVE  = 3'b011,
    ST_ERASE = 3'b010,
    ST_PROG  = 3'b110
  } ecr_state_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } ecr_wr_t;

  function automatic logic [7:0] ecr_crc8(input logic [7:0] crc, input logic [7:0] din);
    logic [7:0] c;
    c = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : ecr_crc8

endpackage : ecr_pkg

//--- verification/ecr_ctrl_asserts.sv
/* Concurrent checks on the ports of the control core.
   Assumes it is bound to ecr_ctrl and sees only that module's ports. */
`timescale 1ns/1ns
module ecr_ctrl_asserts
  import ecr_pkg::*;
#(
  parameter int OP_CYCLES = OP_CYC
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Watched ports
  input wire logic       txn_start,
  input wire logic       txn_stop,
  input wire logic       wr_valid,
  input wire ecr_wr_t    wr,
  input wire logic       rd_req,
  input wire logic       rd_req_ready,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic       rd_ready
);
  // ****************************************
  // Helper counters
  // ****************************************
  // The occupancy model lets the checker see FIFO depth without reaching inside.
  logic [5:0] cyc_q;
  logic [4:0] occ_q;
  always_ff @(posedge clk) begin
    if (!rstn) cyc_q <= 6'h00;
    else if (cyc_q != 6'h3f) cyc_q <= cyc_q + 6'h01;
  end
  always_ff @(posedge clk) begin
    if (!rstn) occ_q <= 5'h00;
    else occ_q <= occ_q + 5'(rd_req && rd_req_ready) - 5'(rd_valid && rd_ready);
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_take;
    rd_req && rd_req_ready;
  endsequence
  sequence s_wait;
    rd_valid && !rd_ready;
  endsequence
  AST_RST_OUT: assert property ($rose(rstn) |-> !rd_valid && !rd_req_ready)
    else $error("Outputs not idle after reset.");
  AST_LOAD_HOLD: assert property (cyc_q < 6'd31 |-> !rd_req_ready)
    else $error("Read taken during start-up load.");
  AST_LOAD_END: assert property (cyc_q == 6'd40 |-> rd_req_ready)
    else $error("Start-up load did not finish.");
  AST_ANSWER: assert property (s_take ##0 !rd_valid |=> rd_valid)
    else $error("Read answer missing.");
  AST_HOLD: assert property (s_wait |=> rd_valid && $stable(rd_data))
    else $error("Read data dropped before drain.");
  AST_NO_ANSWER: assert property (!rd_valid && !(rd_req && rd_req_ready) |=> !rd_valid)
    else $error("Read answer without request.");
  AST_VALID_OCC: assert property (rd_valid == (occ_q != 5'h00))
    else $error("Read valid disagrees with queued count.");
  AST_FULL: assert property (occ_q >= 5'd15 |=> !rd_req_ready)
    else $error("Read taken while queue full.");
endmodule : ecr_ctrl_asserts

bind ecr_ctrl ecr_ctrl_asserts #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .txn_start(txn_start), .txn_stop(txn_stop), .wr_valid(wr_valid),
  .wr(wr), .rd_req(rd_req), .rd_req_ready(rd_req_ready), .rd_valid(rd_valid),
  .rd_data(rd_data), .rd_ready(rd_ready)
);

//--- verification/ecr_ctrl_tb.sv
/* Self-checking bench for the control core through the host model.
   Assumes a shortened operation time set by the OP_CYCLES parameter. */
`timescale 1ns/1ns
module ecr_ctrl_tb
  import ecr_pkg::*;
;
  localparam int OPC = 40;
  logic       clk;
  logic       rstn;
  logic       txn_start;
  logic       txn_stop;
  logic       wr_valid;
  ecr_wr_t    wr;
  logic       rd_req;
  logic       rd_req_ready;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       rd_ready;
  logic [7:0] v;
  int         fail_count;
  int         cmp_count;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ecr_ctrl #(.OP_CYCLES(OPC)) DUT (
    .clk(clk), .rstn(rstn), .txn_start(txn_start), .txn_stop(txn_stop), .wr_valid(wr_valid),
    .wr(wr), .rd_req(rd_req), .rd_req_ready(rd_req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready(rd_ready)
  );
  ecr_host host (
    .clk(clk), .rd_req_ready(rd_req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .txn_start(txn_start), .txn_stop(txn_stop), .wr_valid(wr_valid), .wr(wr),
    .rd_req(rd_req), .rd_ready(rd_ready)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    host.rd(a, 1, 1'b0);
    d = (host.got.size() == 1) ? host.got[0] : 8'hxx;
  endtask : rdr
  task automatic idle();
    logic [7:0] c;
    c = 8'h04;
    for (int i = 0; i < 40 && c[BIT_BUSY] !== 1'b0; i++) rdr(ADR_CTL, c);
    chk("busy end", c & 8'h04, 8'h00);
  endtask : idle
  task automatic go(input logic [7:0] c);
    host.wr1(ADR_UNLK, UNLOCK_CODE);
    host.wr1(ADR_CTL, c);
  endtask : go
  task automatic do_rst();
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (50) @(negedge clk);
  endtask : do_rst
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    do_rst();
    rdr(ADR_MEM, v);
    chk("memory_start_address reset", v, MEMORY_START_ADDRESS_RST);
    rdr(ADR_CTL, v);
    chk("ctl reset", v & 8'h5f, 8'h10);
    for (int i = 0; i < 32; i++) host.wr1(8'(i), 8'(i) + 8'h40);
    host.wr1(ADR_CTL, 8'h50);
    repeat (40) @(negedge clk);
    rdr(ADR_CTL, v);
    chk("commit done", v & 8'h5f, 8'h10);
    host.wr1(ADR_UNLK, 8'h12);
    host.wr1(ADR_CTL, 8'h11);
    rdr(ADR_CTL, v);
    chk("bad code", v & 8'h5f, 8'h10);
    host.wr1(ADR_UNLK, UNLOCK_CODE);
    host.wr1(ADR_MEM, 8'h00);
    host.wr1(ADR_CTL, 8'h11);
    rdr(ADR_CTL, v);
    chk("stale code", v & 8'h5f, 8'h10);
    go(8'h11);
    rdr(ADR_DAT, v);
    chk("busy data", v, 8'h00);
    rdr(ADR_CTL, v);
    chk("busy prog", v & 8'h04, 8'h04);
    idle();
    host.wr1(ADR_CTL, 8'h18);
    repeat (40) @(negedge clk);
    rdr(ADR_CTL, v);
    chk("good crc", v & 8'h7f, 8'h10);
    rdr(8'h05, v);
    chk("loaded reg", v, 8'h45);
    rdr(ADR_CNT, v);
    chk("count one", v, 8'h01);
    host.wr1(ADR_MEM, 8'h45);
    rdr(ADR_MEM, v);
    chk("memory_start_address", v, 8'h45);
    host.rd(ADR_DAT, 4, 1'b0);
    for (int i = 0; i < 4; i++) chk("stream", host.got[i], 8'h45 + 8'(i));
    host.rd(ADR_MEM, 3, 1'b0);
    chk("via inc a", host.got[0], 8'h45);
    chk("via inc b", host.got[1], 8'h45);
    chk("via inc c", host.got[2], 8'h46);
    host.rd(ADR_DAT, 20, 1'b1);
    chk("fifo taken", 8'(host.taken), 8'd15);
    chk("fifo last", host.got[14], 8'h53);
    host.wr1(8'h00, 8'h99);
    host.wr1(ADR_CTL, 8'h40);
    repeat (40) @(negedge clk);
    go(8'h03);
    repeat (60) @(negedge clk);
    rdr(ADR_CTL, v);
    chk("busy both", v & 8'h04, 8'h04);
    idle();
    host.wr1(ADR_CTL, 8'h08);
    repeat (40) @(negedge clk);
    rdr(ADR_CTL, v);
    chk("crc error", v & 8'h20, 8'h20);
    rdr(8'h00, v);
    chk("programmed", v, 8'h99);
    rdr(ADR_CNT, v);
    chk("count two", v, 8'h02);
    go(8'h02);
    rdr(ADR_CTL, v);
    chk("busy erase", v & 8'h06, 8'h06);
    idle();
    host.wr1(ADR_CTL, 8'h08);
    repeat (40) @(negedge clk);
    rdr(8'h00, v);
    chk("erased", v, ERASE_VAL);
    rdr(ADR_CNT, v);
    chk("count three", v, 8'h03);
    chk("drain", 8'(host.drain_tmo), 8'h00);
    host.wr1(ADR_MEM, 8'h12);
    do_rst();
    rdr(ADR_MEM, v);
    chk("memory_start_address rerst", v, MEMORY_START_ADDRESS_RST);
    wrap_up();
  end
endmodule : ecr_ctrl_tb

//--- verification/ecr_host.sv
/* Host model: frames transactions, writes bytes and requests and drains read bytes.
   Assumes the bench calls its tasks; it drives on the falling clock edge. */
`timescale 1ns/1ns
module ecr_host
  import ecr_pkg::*;
(
  // Clock and answers
  input  wire logic       clk,
  input  wire logic       rd_req_ready,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  // Requests
  output      logic       txn_start,
  output      logic       txn_stop,
  output      logic       wr_valid,
  output      ecr_wr_t    wr,
  output      logic       rd_req,
  output      logic       rd_ready
);
  logic [7:0] got[$];
  int         taken;
  int         drain_tmo;
  initial begin
    txn_start = 1'b0;
    txn_stop  = 1'b0;
    wr_valid  = 1'b0;
    wr        = '0;
    rd_req    = 1'b0;
    rd_ready  = 1'b0;
  end
  always @(posedge clk) begin
    if (rd_valid && rd_ready) got.push_back(rd_data);
    if (rd_req && rd_req_ready) taken++;
  end
  task automatic frame(input logic stop);
    @(negedge clk);
    txn_start = !stop;
    txn_stop  = stop;
    @(negedge clk);
    txn_start = 1'b0;
    txn_stop  = 1'b0;
  endtask : frame
  task automatic put(input logic first, input logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'b1;
    wr       = '{first: first, data: b};
    @(negedge clk);
    wr_valid = 1'b0;
    // Released data shows the inverse, so a stale byte can never pass for a fresh one.
    wr.data  = ~b;
  endtask : put
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    frame(1'b0);
    put(1'b1, a);
    put(1'b0, d);
    frame(1'b1);
  endtask : wr1
  task automatic rd(input logic [7:0] a, input int n, input logic stall);
    int w;
    got.delete();
    taken    = 0;
    rd_ready = !stall;
    frame(1'b0);
    put(1'b1, a);
    for (int i = 0; i < n; i++) begin
      w = 0;
      while (!rd_req_ready && w < 60) begin
        @(negedge clk);
        w++;
      end
      if (rd_req_ready) begin
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        @(negedge clk);
      end
    end
    rd_ready = 1'b1;
    w = 0;
    while (rd_valid && w < 60) begin
      @(negedge clk);
      w++;
    end
    if (rd_valid) drain_tmo++;
    frame(1'b1);
  endtask : rd
endmodule : ecr_host
